// File: pkg/gpio_dual_map.svh
// register offsets, field layout, reset values for the dual gpio port block
`ifndef GPIO_DUAL_MAP_SVH
`define GPIO_DUAL_MAP_SVH
`define WIDE_OUT_LATCH_OFS 12'h007
`define NARROW_OUT_LATCH_OFS 12'h008
`define WIDE_PIN_READ_OFS 12'h014
`define WIDE_DIRECTION_OFS 12'hF21
`define NARROW_DIRECTION_OFS 12'hF22
`define WIDE_FUNC_SELECT_OFS 12'hF3B
`define NARROW_FUNC_SELECT_OFS 12'hF3C
`define WIDE_SEL_MASK 8'h1F
`define NARROW_MASK 8'h03
`define REG_RESET 8'h00
`endif

// File: pkg/gpio_dual_pkg.sv
// types for the dual gpio port block
package gpio_dual_pkg;
    typedef struct packed {
        logic [7:0] wide_out_latch;
        logic [1:0] narrow_out_latch;
        logic [7:0] wide_direction;
        logic [1:0] narrow_direction;
        logic [4:0] wide_func_select;
        logic [1:0] narrow_func_select;
    } gpio_regs_t;
    typedef struct packed {
        logic divider_out;
        logic timer_a_pulse_out_1;
        logic timer_a_pulse_out_0;
        logic timer_one_pulse_out;
        logic timer_one_pwm_out;
        logic timer_zero_pulse_out;
        logic timer_zero_pwm_out;
        logic timer_three_pulse_out;
        logic timer_three_pwm_out;
        logic timer_two_pulse_out;
        logic timer_two_pwm_out;
        logic timer_one_pwm_sel;
        logic timer_zero_pwm_sel;
        logic timer_three_pwm_sel;
        logic timer_two_pwm_sel;
    } periph_out_t;
    typedef struct packed {
        logic ext_irq_in_c;
        logic ext_irq_in_b;
        logic ext_irq_in_a;
        logic timer_a_in_1;
        logic timer_a_in_0;
        logic timer_one_in;
        logic timer_zero_in;
        logic timer_three_in;
        logic timer_two_in;
    } periph_in_t;
endpackage

// File: hw/gpio_dual.sv
// apb register block and pin logic for an eight-bit and a two-bit gpio port
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps
`include "gpio_dual_map.svh"
module gpio_dual (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire gpio_dual_pkg::periph_out_t periph_out,
    output gpio_dual_pkg::periph_in_t periph_in,
    input wire logic [7:0] wide_pin_in,
    output logic [7:0] wide_pin_out,
    output logic [7:0] wide_pin_oe,
    input wire logic [1:0] narrow_pin_in,
    output logic [1:0] narrow_pin_out,
    output logic [1:0] narrow_pin_oe
);
    import gpio_dual_pkg::*;

    gpio_regs_t regs_q;
    gpio_regs_t regs_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic [11:0] reg_ofs;
    logic hit;
    logic access;
    logic [7:0] rd_byte;
    logic [7:0] wd;
    logic [7:0] wide_alt;
    logic [1:0] narrow_alt;

    // printed offsets are not all word aligned, so each is an index: byte addr = 4 * index
    assign reg_ofs = paddr[13:2];
    assign access = psel && penable;
    assign pready = 1'b1;
    assign wd = pwdata[7:0];

    // decode and read mux
    always_comb begin
        hit = 1'b1;
        rd_byte = 8'h00;
        if (reg_ofs == `WIDE_OUT_LATCH_OFS) begin
            rd_byte = regs_q.wide_out_latch;
        end else if (reg_ofs == `NARROW_OUT_LATCH_OFS) begin
            rd_byte = {6'h00, regs_q.narrow_out_latch};
        end else if (reg_ofs == `WIDE_PIN_READ_OFS) begin
            rd_byte = wide_pin_in & ~regs_q.wide_direction;
        end else if (reg_ofs == `WIDE_DIRECTION_OFS) begin
            rd_byte = regs_q.wide_direction;
        end else if (reg_ofs == `NARROW_DIRECTION_OFS) begin
            rd_byte = {6'h00, regs_q.narrow_direction};
        end else if (reg_ofs == `WIDE_FUNC_SELECT_OFS) begin
            rd_byte = {3'h0, regs_q.wide_func_select};
        end else if (reg_ofs == `NARROW_FUNC_SELECT_OFS) begin
            rd_byte = {6'h00, regs_q.narrow_func_select};
        end else begin
            hit = 1'b0;
        end
        // misaligned or high address bits also miss
        if (paddr[1:0] != 2'h0 || paddr[31:14] != 18'h0) begin
            hit = 1'b0;
        end
    end

    assign pslverr = access && !hit;

    always_comb begin
        regs_d = regs_q;
        prdata_d = prdata_q;
        // captured at the setup edge so prdata comes straight from a flop in the access cycle
        if (psel && !penable && hit && !pwrite) begin
            prdata_d = {24'h000000, rd_byte};
        end
        if (access && hit && pwrite && pstrb[0]) begin
            if (reg_ofs == `WIDE_OUT_LATCH_OFS) begin
                regs_d.wide_out_latch = wd;
            end else if (reg_ofs == `NARROW_OUT_LATCH_OFS) begin
                regs_d.narrow_out_latch = wd[1:0];
            end else if (reg_ofs == `WIDE_DIRECTION_OFS) begin
                regs_d.wide_direction = wd;
            end else if (reg_ofs == `NARROW_DIRECTION_OFS) begin
                regs_d.narrow_direction = wd[1:0];
            end else if (reg_ofs == `WIDE_FUNC_SELECT_OFS) begin
                regs_d.wide_func_select = wd[4:0];
            end else if (reg_ofs == `NARROW_FUNC_SELECT_OFS) begin
                regs_d.narrow_func_select = wd[1:0];
            end
            // pin read register ignores writes
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            regs_q <= '0;
            prdata_q <= 32'h00000000;
        end else begin
            regs_q <= regs_d;
            prdata_q <= prdata_d;
        end
    end

    // holds the last good read until the next one; a refused read leaves it alone
    assign prdata = prdata_q;

    // alternate outputs; timers zero to three pick pulse or pwm by the timer's own mode, timer a is pulse only
    always_comb begin
        wide_alt = {3'h0,
                    periph_out.divider_out,
                    periph_out.timer_a_pulse_out_1,
                    periph_out.timer_a_pulse_out_0,
                    periph_out.timer_one_pwm_sel ? periph_out.timer_one_pwm_out
                                                 : periph_out.timer_one_pulse_out,
                    periph_out.timer_zero_pwm_sel ? periph_out.timer_zero_pwm_out
                                                  : periph_out.timer_zero_pulse_out};
        narrow_alt = {periph_out.timer_three_pwm_sel ? periph_out.timer_three_pwm_out
                                                     : periph_out.timer_three_pulse_out,
                      periph_out.timer_two_pwm_sel ? periph_out.timer_two_pwm_out
                                                   : periph_out.timer_two_pulse_out};
    end

    // pin drive is combinational from registers, so a write shows one cycle later
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (i < 5 && regs_q.wide_func_select[i % 5]) begin
                wide_pin_out[i] = wide_alt[i];
            end else begin
                wide_pin_out[i] = regs_q.wide_out_latch[i];
            end
        end
        for (int j = 0; j < 2; j++) begin
            if (regs_q.narrow_func_select[j]) begin
                narrow_pin_out[j] = narrow_alt[j];
            end else begin
                narrow_pin_out[j] = regs_q.narrow_out_latch[j];
            end
        end
    end

    assign wide_pin_oe = regs_q.wide_direction;
    assign narrow_pin_oe = regs_q.narrow_direction;

    // secondary inputs only see the pin while in input mode, else held low
    always_comb begin
        periph_in.ext_irq_in_c = wide_pin_in[7] & ~regs_q.wide_direction[7];
        periph_in.ext_irq_in_b = wide_pin_in[6] & ~regs_q.wide_direction[6];
        periph_in.ext_irq_in_a = wide_pin_in[5] & ~regs_q.wide_direction[5];
        periph_in.timer_a_in_1 = wide_pin_in[3] & ~regs_q.wide_direction[3];
        periph_in.timer_a_in_0 = wide_pin_in[2] & ~regs_q.wide_direction[2];
        periph_in.timer_one_in = wide_pin_in[1] & ~regs_q.wide_direction[1];
        periph_in.timer_zero_in = wide_pin_in[0] & ~regs_q.wide_direction[0];
        periph_in.timer_three_in = narrow_pin_in[1] & ~regs_q.narrow_direction[1];
        periph_in.timer_two_in = narrow_pin_in[0] & ~regs_q.narrow_direction[0];
    end

    AST_PIN_READ_MASK: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pwrite && reg_ofs == `WIDE_PIN_READ_OFS && hit)
            |-> ((prdata[7:0] & regs_q.wide_direction) == 8'h00))
        else $error("pin read shows an output-mode bit");
    AST_DIR_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && pstrb[0] && hit && reg_ofs == `WIDE_DIRECTION_OFS)
            |=> (wide_pin_oe == $past(pwdata[7:0])))
        else $error("direction write not on enables next cycle");
    AST_NARROW_DIR: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && pstrb[0] && hit && reg_ofs == `NARROW_DIRECTION_OFS)
            |=> (narrow_pin_oe == $past(pwdata[1:0])))
        else $error("narrow direction write lost");
    AST_LATCH_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && pstrb[0] && hit && reg_ofs == `WIDE_OUT_LATCH_OFS
            && regs_q.wide_func_select == 5'h00)
            |=> (wide_pin_out == $past(pwdata[7:0])))
        else $error("latch write not on pins");
    AST_NARROW_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pwrite && hit && reg_ofs == `NARROW_OUT_LATCH_OFS)
            |-> (prdata[7:2] == 6'h00))
        else $error("narrow latch upper bits nonzero");
    AST_SEL_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pwrite && hit && reg_ofs == `WIDE_FUNC_SELECT_OFS)
            |-> (prdata[7:5] == 3'h0))
        else $error("select upper bits nonzero");
    AST_DIVIDER_OUT: assert property (@(posedge pclk) disable iff (!presetn)
        regs_q.wide_func_select[4] |-> (wide_pin_out[4] == periph_out.divider_out))
        else $error("divider not routed");
    AST_TIMER_IN: assert property (@(posedge pclk) disable iff (!presetn)
        !regs_q.narrow_direction[1] |-> (periph_in.timer_three_in == narrow_pin_in[1]))
        else $error("timer three input not fed");
    AST_IRQ_IN: assert property (@(posedge pclk) disable iff (!presetn)
        !regs_q.wide_direction[7] |-> (periph_in.ext_irq_in_c == wide_pin_in[7]))
        else $error("irq input not fed");
    AST_NARROW_SEL: assert property (@(posedge pclk) disable iff (!presetn)
        (!regs_q.narrow_func_select[0]) |-> (narrow_pin_out[0] == regs_q.narrow_out_latch[0]))
        else $error("narrow latch not routed");

    // register writes land where software expects them
    AST_NARROW_LATCH_DRIVE: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && pstrb[0] && hit && reg_ofs == `NARROW_OUT_LATCH_OFS
            && regs_q.narrow_func_select == 2'h0)
            |=> (narrow_pin_out == $past(pwdata[1:0])))
        else $error("narrow latch write not on pins");

    AST_SEL_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && pstrb[0] && hit && reg_ofs == `WIDE_FUNC_SELECT_OFS)
            |=> (regs_q.wide_func_select == $past(pwdata[4:0])))
        else $error("select write lost");

    AST_NARROW_SEL_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && pstrb[0] && hit && reg_ofs == `NARROW_FUNC_SELECT_OFS)
            |=> (regs_q.narrow_func_select == $past(pwdata[1:0])))
        else $error("narrow select write lost");

    // alternate outputs reach the pins they belong to, and unselected pins follow the latch
    AST_TIMER_A1_OUT: assert property (@(posedge pclk) disable iff (!presetn)
        regs_q.wide_func_select[3] |-> (wide_pin_out[3] == periph_out.timer_a_pulse_out_1))
        else $error("timer a pulse 1 not routed");

    AST_TIMER_A0_OUT: assert property (@(posedge pclk) disable iff (!presetn)
        regs_q.wide_func_select[2] |-> (wide_pin_out[2] == periph_out.timer_a_pulse_out_0))
        else $error("timer a pulse 0 not routed");

    AST_TIMER_ONE_OUT: assert property (@(posedge pclk) disable iff (!presetn)
        regs_q.wide_func_select[1] |-> (wide_pin_out[1] == (periph_out.timer_one_pwm_sel
            ? periph_out.timer_one_pwm_out : periph_out.timer_one_pulse_out)))
        else $error("timer one output not routed");

    AST_TIMER_ZERO_OUT: assert property (@(posedge pclk) disable iff (!presetn)
        regs_q.wide_func_select[0] |-> (wide_pin_out[0] == (periph_out.timer_zero_pwm_sel
            ? periph_out.timer_zero_pwm_out : periph_out.timer_zero_pulse_out)))
        else $error("timer zero output not routed");

    AST_TIMER_THREE_OUT: assert property (@(posedge pclk) disable iff (!presetn)
        regs_q.narrow_func_select[1] |-> (narrow_pin_out[1] == (periph_out.timer_three_pwm_sel
            ? periph_out.timer_three_pwm_out : periph_out.timer_three_pulse_out)))
        else $error("timer three output not routed");

    AST_TIMER_TWO_OUT: assert property (@(posedge pclk) disable iff (!presetn)
        regs_q.narrow_func_select[0] |-> (narrow_pin_out[0] == (periph_out.timer_two_pwm_sel
            ? periph_out.timer_two_pwm_out : periph_out.timer_two_pulse_out)))
        else $error("timer two output not routed");

    AST_WIDE_LATCH_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
        ((wide_pin_out ^ regs_q.wide_out_latch) & ~{3'h0, regs_q.wide_func_select}) == 8'h00)
        else $error("wide port pin not on latch");

    AST_NARROW_LATCH_ROUTE: assert property (@(posedge pclk) disable iff (!presetn)
        ((narrow_pin_out ^ regs_q.narrow_out_latch) & ~regs_q.narrow_func_select) == 2'h0)
        else $error("narrow port pin not on latch");

    // secondary inputs follow the pins in input mode and stay low otherwise
    AST_IRQ_B_IN: assert property (@(posedge pclk) disable iff (!presetn)
        !regs_q.wide_direction[6] |-> (periph_in.ext_irq_in_b == wide_pin_in[6]))
        else $error("irq b input not fed");

    AST_IRQ_A_IN: assert property (@(posedge pclk) disable iff (!presetn)
        !regs_q.wide_direction[5] |-> (periph_in.ext_irq_in_a == wide_pin_in[5]))
        else $error("irq a input not fed");

    AST_TIMER_A1_IN: assert property (@(posedge pclk) disable iff (!presetn)
        !regs_q.wide_direction[3] |-> (periph_in.timer_a_in_1 == wide_pin_in[3]))
        else $error("timer a input 1 not fed");

    AST_TIMER_A0_IN: assert property (@(posedge pclk) disable iff (!presetn)
        !regs_q.wide_direction[2] |-> (periph_in.timer_a_in_0 == wide_pin_in[2]))
        else $error("timer a input 0 not fed");

    AST_TIMER_ONE_IN: assert property (@(posedge pclk) disable iff (!presetn)
        !regs_q.wide_direction[1] |-> (periph_in.timer_one_in == wide_pin_in[1]))
        else $error("timer one input not fed");

    AST_TIMER_ZERO_IN: assert property (@(posedge pclk) disable iff (!presetn)
        !regs_q.wide_direction[0] |-> (periph_in.timer_zero_in == wide_pin_in[0]))
        else $error("timer zero input not fed");

    AST_TIMER_TWO_IN: assert property (@(posedge pclk) disable iff (!presetn)
        !regs_q.narrow_direction[0] |-> (periph_in.timer_two_in == narrow_pin_in[0]))
        else $error("timer two input not fed");

    AST_WIDE_IN_MASK: assert property (@(posedge pclk) disable iff (!presetn)
        ({periph_in.ext_irq_in_c, periph_in.ext_irq_in_b, periph_in.ext_irq_in_a, 1'b0,
            periph_in.timer_a_in_1, periph_in.timer_a_in_0, periph_in.timer_one_in,
            periph_in.timer_zero_in} & regs_q.wide_direction) == 8'h00)
        else $error("secondary input seen in output mode");

    AST_NARROW_IN_MASK: assert property (@(posedge pclk) disable iff (!presetn)
        ({periph_in.timer_three_in, periph_in.timer_two_in} & regs_q.narrow_direction) == 2'h0)
        else $error("narrow secondary input seen in output mode");

    // refused or ignored writes leave the registers alone
    AST_MISALIGNED_NO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && paddr[1:0] != 2'h0)
            |=> (regs_q.wide_out_latch == $past(regs_q.wide_out_latch)))
        else $error("misaligned write changed the latch");

    AST_STRB_OFF_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && !pstrb[0]) |=> $stable(regs_q))
        else $error("write with lane off changed a register");

    AST_PIN_READ_NO_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (access && pwrite && reg_ofs == `WIDE_PIN_READ_OFS) |=> $stable(regs_q))
        else $error("pin read register took a write");

    // read data seen in the access cycle
    AST_NARROW_DIR_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pwrite && hit && reg_ofs == `NARROW_DIRECTION_OFS)
            |-> (prdata[7:2] == 6'h00))
        else $error("narrow direction upper bits nonzero");

    AST_NARROW_SEL_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pwrite && hit && reg_ofs == `NARROW_FUNC_SELECT_OFS)
            |-> (prdata[7:2] == 6'h00))
        else $error("narrow select upper bits nonzero");

    AST_READ_HIGH_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pwrite && hit) |-> (prdata[31:8] == 24'h000000))
        else $error("read data above the low byte nonzero");

    AST_WIDE_DIR_READBACK: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pwrite && hit && reg_ofs == `WIDE_DIRECTION_OFS)
            |-> (prdata[7:0] == regs_q.wide_direction))
        else $error("direction readback wrong");

    AST_NARROW_DIR_READBACK: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pwrite && hit && reg_ofs == `NARROW_DIRECTION_OFS)
            |-> (prdata[1:0] == regs_q.narrow_direction))
        else $error("narrow direction readback wrong");

    AST_LATCH_READBACK: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pwrite && hit && reg_ofs == `WIDE_OUT_LATCH_OFS)
            |-> (prdata[7:0] == regs_q.wide_out_latch))
        else $error("latch readback wrong");

    AST_NARROW_LATCH_READBACK: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pwrite && hit && reg_ofs == `NARROW_OUT_LATCH_OFS)
            |-> (prdata[1:0] == regs_q.narrow_out_latch))
        else $error("narrow latch readback wrong");

    AST_SEL_READBACK: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pwrite && hit && reg_ofs == `WIDE_FUNC_SELECT_OFS)
            |-> (prdata[4:0] == regs_q.wide_func_select))
        else $error("select readback wrong");

    // pin level as it stood at the setup edge, masked by direction
    AST_PIN_READ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
        (access && !pwrite && hit && reg_ofs == `WIDE_PIN_READ_OFS)
            |-> (prdata[7:0] == ($past(wide_pin_in) & ~regs_q.wide_direction)))
        else $error("pin read level wrong");

endmodule // gpio_dual

// File: verif/pin_partner.sv
// far-side pad model: outside sources on the pins, port's own level where it drives
`timescale 1ns/1ps
module pin_partner (
    input wire logic [7:0] wide_pin_out,
    input wire logic [7:0] wide_pin_oe,
    input wire logic [1:0] narrow_pin_out,
    input wire logic [1:0] narrow_pin_oe,
    input wire logic [7:0] wide_ext,
    input wire logic [1:0] narrow_ext,
    output logic [7:0] wide_pin_in,
    output logic [1:0] narrow_pin_in
);
    // a driven pad reads back the port level, an undriven one the outside source
    assign wide_pin_in = (wide_pin_oe & wide_pin_out) | (~wide_pin_oe & wide_ext);
    assign narrow_pin_in = (narrow_pin_oe & narrow_pin_out) | (~narrow_pin_oe & narrow_ext);
endmodule // pin_partner

// File: verif/tb.sv
// self-checking bench for the dual gpio port block
`timescale 1ns/1ps
`include "gpio_dual_map.svh"
module tb;
    import gpio_dual_pkg::*;
    localparam logic [11:0] IDX [6] = '{`WIDE_OUT_LATCH_OFS, `NARROW_OUT_LATCH_OFS,
        `WIDE_DIRECTION_OFS, `NARROW_DIRECTION_OFS, `WIDE_FUNC_SELECT_OFS,
        `NARROW_FUNC_SELECT_OFS};
    localparam logic [7:0] MSK [6] = '{8'hFF, 8'h03, 8'hFF, 8'h03, 8'h1F, 8'h03};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    periph_out_t periph_out = '0;
    periph_in_t periph_in;
    logic [7:0] wide_pin_in, wide_pin_out, wide_pin_oe;
    logic [7:0] wide_ext = 8'h0;
    logic [1:0] narrow_pin_in, narrow_pin_out, narrow_pin_oe;
    logic [1:0] narrow_ext = 2'h0;
    logic [7:0] regv [6];
    int num_errors = 0;
    int checks = 0;
    always #20 pclk = ~pclk;
    gpio_dual u_gpio_dual (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .periph_out(periph_out), .periph_in(periph_in),
        .wide_pin_in(wide_pin_in), .wide_pin_out(wide_pin_out), .wide_pin_oe(wide_pin_oe),
        .narrow_pin_in(narrow_pin_in), .narrow_pin_out(narrow_pin_out),
        .narrow_pin_oe(narrow_pin_oe));
    pin_partner u_pin_partner (.wide_pin_out(wide_pin_out), .wide_pin_oe(wide_pin_oe),
        .narrow_pin_out(narrow_pin_out), .narrow_pin_oe(narrow_pin_oe), .wide_ext(wide_ext),
        .narrow_ext(narrow_ext), .wide_pin_in(wide_pin_in), .narrow_pin_in(narrow_pin_in));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [31:0] addr, input logic [7:0] data);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= {24'h0, data};
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // expected pad levels {narrow, wide} from the shadow registers
    function automatic logic [9:0] exp_pins(input periph_out_t p);
        logic [7:0] alt;
        logic [1:0] nalt;
        alt = {3'h0, p.divider_out, p.timer_a_pulse_out_1, p.timer_a_pulse_out_0,
            p.timer_one_pwm_sel ? p.timer_one_pwm_out : p.timer_one_pulse_out,
            p.timer_zero_pwm_sel ? p.timer_zero_pwm_out : p.timer_zero_pulse_out};
        nalt = {p.timer_three_pwm_sel ? p.timer_three_pwm_out : p.timer_three_pulse_out,
            p.timer_two_pwm_sel ? p.timer_two_pwm_out : p.timer_two_pulse_out};
        return {(regv[5][1:0] & nalt) | (~regv[5][1:0] & regv[1][1:0]),
            (regv[4] & alt) | (~regv[4] & regv[0])};
    endfunction
    task automatic conclude();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #(20000 * 40);
        num_errors++;
        conclude();
    end
    initial begin
        void'($urandom(32'hB9E2));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        chk({narrow_pin_oe, wide_pin_oe}, 32'h0);
        foreach (IDX[i]) begin
            apb(1'b0, {IDX[i], 2'b00}, 8'h0);
            chk(rd, 32'h0);
            apb(1'b1, {IDX[i], 2'b00}, 8'hFF);
            apb(1'b0, {IDX[i], 2'b00}, 8'h0);
            chk(rd, {24'h0, MSK[i]});
        end
        // a write with its low byte lane off must leave the latch alone
        pstrb <= 4'h0;
        apb(1'b1, {`WIDE_OUT_LATCH_OFS, 2'b00}, 8'h00);
        pstrb <= 4'hF;
        apb(1'b0, {`WIDE_OUT_LATCH_OFS, 2'b00}, 8'h0);
        chk(rd, 32'hFF);
        apb(1'b0, 32'h14, 8'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, 32'h1D, 8'h55);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, {`WIDE_OUT_LATCH_OFS, 2'b00}, 8'h0);
        chk(rd, 32'hFF);
        // the pin read register ignores a write without raising an error
        apb(1'b1, {`WIDE_PIN_READ_OFS, 2'b00}, 8'hA5);
        chk({31'h0, err}, 32'h0);
        for (int k = 0; k < 40; k++) begin
            foreach (IDX[i]) begin
                regv[i] = 8'($urandom) & MSK[i];
                // first pass: every pin an output, alternate where one exists (wide pins 5-7 stay on the latch); second: every pin an input
                if (k < 2) regv[i] = (k == 0) ? MSK[i] : 8'h0;
                apb(1'b1, {IDX[i], 2'b00}, regv[i]);
            end
            #1;
            chk({narrow_pin_out, wide_pin_out}, exp_pins(periph_out));
            @(posedge pclk);
            periph_out <= periph_out_t'($urandom);
            wide_ext <= 8'($urandom);
            narrow_ext <= 2'($urandom);
            @(posedge pclk);
            #1;
            chk({narrow_pin_out, wide_pin_out}, exp_pins(periph_out));
            chk({narrow_pin_oe, wide_pin_oe}, {regv[3][1:0], regv[2]});
            chk(periph_in, {wide_ext[7:5] & ~regv[2][7:5], wide_ext[3:0] & ~regv[2][3:0],
                narrow_ext & ~regv[3][1:0]});
            apb(1'b0, {`WIDE_PIN_READ_OFS, 2'b00}, 8'h0);
            chk(rd, {24'h0, wide_ext & ~regv[2]});
        end
        conclude();
    end
endmodule // tb
